/* File: hdl/asram_pkg.sv */
// Constants and types shared by the static memory controller
package asram_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 4;
    localparam int WORDS = 16384;
    localparam int CLK_PERIOD_NS = 100;
    // Timing of the slowest speed grade, in nanoseconds
    localparam int ADDRESS_TO_DATA_DELAY_NS = 12;
    localparam int WRITE_PULSE_MIN_NS = 9;
    localparam int OUTPUT_TURNOFF_AFTER_WRITE_NS = 3;
    localparam int DATA_SETUP_BEFORE_END_NS = 6;
    localparam int SELECT_TO_WRITE_END_NS = 9;
    localparam int RELEASE_TO_CYCLE_END_NS = 0;
    localparam int READ_CYCLE_MIN_NS = 12;
    localparam int OUTPUT_TURNOFF_AFTER_OE_NS = 3;
    // Least time rounded up to whole cycles, never below one
    function automatic int asram_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int WRITE_TURNOFF_NS = OUTPUT_TURNOFF_AFTER_WRITE_NS + DATA_SETUP_BEFORE_END_NS;
    localparam int WRITE_LOW_NS = (WRITE_TURNOFF_NS > WRITE_PULSE_MIN_NS) ?
        WRITE_TURNOFF_NS : WRITE_PULSE_MIN_NS;
    localparam int WRITE_CYC = asram_cycles(WRITE_LOW_NS);
    localparam int READ_CYC = asram_cycles(ADDRESS_TO_DATA_DELAY_NS);
    localparam int RECOVER_CYC = asram_cycles(RELEASE_TO_CYCLE_END_NS);
    localparam int TURNOFF_CYC = asram_cycles(OUTPUT_TURNOFF_AFTER_OE_NS);
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {
        ASRAM_IDLE = 3'b000,
        ASRAM_RSETUP = 3'b001,
        ASRAM_RWAIT = 3'b010,
        ASRAM_TURN = 3'b011,
        ASRAM_WPULSE = 3'b100,
        ASRAM_RECOVER = 3'b101
    } asram_state_t;
endpackage

/* File: hdl/asram_pins_if.sv */
// Interface carrying the memory strobes between controller and pin driver
`timescale 1ns/1ns
interface asram_pins_if;
    import asram_pkg::*;
    logic selectN;
    logic outEnN;
    logic writeN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic drive;
    modport ctrl (output selectN, outEnN, writeN, addr, wdata, drive);
    modport pins (input selectN, outEnN, writeN, addr, wdata, drive);
endinterface

/* File: hdl/asram_pin_drv.sv */
// Output flops toward the memory pins and two-stage sync of read data
`timescale 1ns/1ns
module asram_pin_drv
    import asram_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // From the sequencer
    asram_pins_if.pins p,
    // Memory pins
    output logic memSelectN,
    output logic memOutEnN,
    output logic memWriteN,
    output logic [ADDR_W-1:0] memAddr,
    output logic [DATA_W-1:0] memDataOut,
    output logic memDataOe,
    input wire logic [DATA_W-1:0] memDataIn,
    // Synchronised read data
    output logic [DATA_W-1:0] dataSync
);
    logic [DATA_W-1:0] sync1Reg;

    // Registered strobes so pins never glitch
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            memSelectN <= 1'b1;
            memOutEnN <= 1'b1;
            memWriteN <= 1'b1;
            memAddr <= '0;
            memDataOut <= '0;
            memDataOe <= 1'b0;
        end
        else if (clkEn)
        begin
            memSelectN <= p.selectN;
            memOutEnN <= p.outEnN;
            memWriteN <= p.writeN;
            memAddr <= p.addr;
            memDataOut <= p.wdata;
            memDataOe <= p.drive;
        end
    end

    // Pins are asynchronous: two flops before use
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1Reg <= '0;
            dataSync <= '0;
        end
        else if (clkEn)
        begin
            sync1Reg <= memDataIn;
            dataSync <= sync1Reg;
        end
    end
endmodule

/* File: hdl/asram_ctrl.sv */
// Controller driving a 16K by 4 asynchronous static memory
// Notes on behaviour
// - Stretch write pulse when output enable low
// - Select-controlled write may keep output enable low
// - Recovery counted from first rising strobe
// - Never drive bus while memory drives it
// - Read keeps write high, address before select; here address and select change on the same pin edge
`timescale 1ns/1ns
module asram_ctrl
    import asram_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int READ_CYCLES = READ_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC,
    parameter int TURNOFF_CYCLES = TURNOFF_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // User request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqWdata,
    // User answer
    output logic rspValid,
    output logic [DATA_W-1:0] rspRdata,
    // Memory pins
    output logic memSelectN,
    output logic memOutEnN,
    output logic memWriteN,
    output logic [ADDR_W-1:0] memAddr,
    output logic [DATA_W-1:0] memDataOut,
    output logic memDataOe,
    input wire logic [DATA_W-1:0] memDataIn
);
    // Strobes toward the pin stage travel together in one bundle
    asram_pins_if pinBus ();

    // Sequencer state and phase counter
    asram_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] dataSync;
    logic cntDone;
    logic readDone;

    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Sync delay of two flops plus the pin register stage
    localparam int SYNC_CYC = 3;

    // Load value so a phase lasts cyc enabled edges; four bits cap it at 16
    function automatic logic [CNT_W-1:0] asram_load(input int cyc);
        return CNT_W'(cyc - 1);
    endfunction

    // Phase end and handshake; ready is combinational so idle takes a request at once
    assign cntDone = (cnt_reg == '0);
    assign reqReady = (state_reg == ASRAM_IDLE);
    // Last edge of the read wait, when the synchronised data has settled
    assign readDone = (state_reg == ASRAM_RWAIT) && cntDone;

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ASRAM_IDLE:
                if (reqValid)
                    state_next = reqWrite ? ASRAM_TURN : ASRAM_RSETUP;
            ASRAM_RSETUP:
                state_next = ASRAM_RWAIT;
            ASRAM_RWAIT:
                if (cntDone)
                    state_next = ASRAM_RECOVER;
            ASRAM_TURN:
                if (cntDone)
                    state_next = ASRAM_WPULSE;
            ASRAM_WPULSE:
                if (cntDone)
                    state_next = ASRAM_RECOVER;
            ASRAM_RECOVER:
                if (cntDone)
                    state_next = ASRAM_IDLE;
            // Unused codes fall back to idle with the pins released
            default:
                state_next = ASRAM_IDLE;
        endcase
    end

    // State register; clock enable freezes everything
    // A frozen write keeps its strobes low, so the same word is simply rewritten
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state_reg <= ASRAM_IDLE;
        else if (clkEn)
            state_reg <= state_next;
    end

    // Phase counter, loaded on each state entry
    // Counts enabled edges only, so clkEn low stretches every phase
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            cnt_reg <= '0;
        else if (clkEn)
        begin
            if (state_next != state_reg)
            begin
                unique case (state_next)
                    ASRAM_RWAIT: cnt_reg <= asram_load(READ_CYCLES + SYNC_CYC);
                    ASRAM_TURN: cnt_reg <= asram_load(TURNOFF_CYCLES);
                    ASRAM_WPULSE: cnt_reg <= asram_load(WRITE_CYCLES);
                    ASRAM_RECOVER: cnt_reg <= asram_load(RECOVER_CYCLES);
                    default: cnt_reg <= '0;
                endcase
            end
            else if (!cntDone)
                cnt_reg <= cnt_reg - CNT_ONE;
        end
    end

    // Capture request; address is held for whole cycle
    // Inputs are sampled only when taken, so later changes cannot reach the pins
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else if (clkEn && reqValid && reqReady)
        begin
            addr_reg <= reqAddr;
            wdata_reg <= reqWdata;
        end
    end

    // Read answer pulse, one cycle per read
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rspValid <= 1'b0;
        else if (clkEn)
            rspValid <= readDone;
    end

    // Read data from synchronised pins; holds until the next answer
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rspRdata <= '0;
        else if (clkEn && readDone)
            rspRdata <= dataSync;
    end

    // Strobe encoding: write keeps output enable high so the memory never drives
    // No stretch is owed, yet write stays low for the turn phase plus a pulse sized from the larger of stretched and plain times
    always_comb
    begin
        pinBus.addr = addr_reg;
        pinBus.wdata = wdata_reg;
        pinBus.selectN = 1'b1;
        pinBus.outEnN = 1'b1;
        pinBus.writeN = 1'b1;
        pinBus.drive = 1'b0;
        unique case (state_reg)
            ASRAM_RSETUP, ASRAM_RWAIT:
            begin
                pinBus.selectN = 1'b0;
                pinBus.outEnN = 1'b0;
                pinBus.writeN = 1'b1;
            end
            ASRAM_TURN:
            begin
                pinBus.selectN = 1'b0;
                pinBus.writeN = 1'b0;
                pinBus.outEnN = 1'b1;
            end
            ASRAM_WPULSE:
            begin
                pinBus.selectN = 1'b0;
                pinBus.writeN = 1'b0;
                pinBus.outEnN = 1'b1;
                pinBus.drive = 1'b1;
            end
            default:
            begin
                pinBus.selectN = 1'b1;
            end
        endcase
    end

    // Pin flops and read-data synchroniser
    asram_pin_drv pinDrv (
        .clock(clock),
        .resetn(resetn),
        .clkEn(clkEn),
        .p(pinBus.pins),
        .memSelectN(memSelectN),
        .memOutEnN(memOutEnN),
        .memWriteN(memWriteN),
        .memAddr(memAddr),
        .memDataOut(memDataOut),
        .memDataOe(memDataOe),
        .memDataIn(memDataIn),
        .dataSync(dataSync)
    );
endmodule

/* File: test/asram_ctrl_properties.sv */
// Pin-level timing checks for the static memory controller
`timescale 1ns/1ns
module asram_ctrl_properties
    import asram_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // User side
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic reqWrite,
    input wire logic rspValid,
    // Memory pins
    input wire logic memSelectN,
    input wire logic memOutEnN,
    input wire logic memWriteN,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic memDataOe
);
    default clocking cb @(posedge clock); endclocking
    // Frozen cycles abort any window that is in progress
    default disable iff (!resetn || !clkEn);
    // Bus driven only inside a write overlap, memory outputs off, so no fight
    property p_fight; memDataOe |-> memOutEnN && !memWriteN && !memSelectN; endproperty
    a_fight: assert property (p_fight) else $error("data driven outside write");
    // Outputs only on with write high
    property p_rdwe; !memOutEnN |-> memWriteN; endproperty
    a_rdwe: assert property (p_rdwe) else $error("output enable with write low");
    // Address held steady on each edge where select stays low from the edge before
    property p_addr; !memSelectN && $past(!memSelectN) |-> $stable(memAddr); endproperty
    a_addr: assert property (p_addr) else $error("address moved while selected");
    // Read answer arrives within the fixed pipeline
    property p_rsp; reqValid && reqReady && !reqWrite |-> ##[5:8] rspValid; endproperty
    a_rsp: assert property (p_rsp) else $error("read answer missing");
    // A taken write opens the overlap soon
    property p_wr; reqValid && reqReady && reqWrite |-> ##[1:3] !memSelectN && !memWriteN;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobes missing");
    // Outputs stay disabled through the pulse, so no stretch is owed
    property p_stretch; !memWriteN |-> memOutEnN; endproperty
    a_stretch: assert property (p_stretch) else $error("output enable low in write");
    // Select and write end together, bus released the same edge
    property p_rec; $rose(memWriteN) |-> memSelectN && !memDataOe; endproperty
    a_rec: assert property (p_rec) else $error("write end out of order");
    // A taken request blocks new ones for the next three cycles
    property p_busy; reqValid && reqReady |=> !reqReady [*3]; endproperty
    a_busy: assert property (p_busy) else $error("ready too early");
    c_write: cover property (reqValid && reqReady && reqWrite);
    c_read: cover property (reqValid && reqReady && !reqWrite);
    c_answer: cover property (rspValid);
endmodule

bind asram_ctrl asram_ctrl_properties chk_u (
    .clock(clock), .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .rspValid(rspValid), .memSelectN(memSelectN),
    .memOutEnN(memOutEnN), .memWriteN(memWriteN), .memAddr(memAddr), .memDataOe(memDataOe)
);

/* File: test/asram_mem_model.sv */
// Behavioural 16K by 4 static memory facing the controller
`timescale 1ns/1ns
module asram_mem_model
    import asram_pkg::*;
#(
    parameter int ACCESS_NS = ADDRESS_TO_DATA_DELAY_NS
)
(
    // Strobes and address
    input wire logic selectN,
    input wire logic outEnN,
    input wire logic writeN,
    input wire logic [ADDR_W-1:0] addr,
    // Shared data bus
    input wire logic [DATA_W-1:0] busIn,
    input wire logic busDriven,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe
);
    logic [DATA_W-1:0] cells [WORDS];
    logic [DATA_W-1:0] lastOut = 4'h0;
    // Drive only when selected, output on, write off; late select stays off
    assign dataOe = !selectN && !outEnN && writeN;
    // Floating pins show the inverse of the last word, never a lucky match
    assign #(ACCESS_NS) dataOut = dataOe ? cells[addr] : ~lastOut;
    always @(dataOut)
        if (dataOe)
            lastOut = dataOut;
    // Cells change only in the select and write overlap; otherwise they keep
    always @*
        if (!selectN && !writeN && busDriven)
            cells[addr] = busIn;
endmodule

/* File: test/tb.sv */
// Self-checking bench for the static memory controller
`timescale 1ns/1ns
module tb;
    import asram_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic reqValid = 1'b0;
    logic clkEn = 1'b1;
    logic reqWrite = 1'b0;
    logic [ADDR_W-1:0] reqAddr = 14'h0000;
    logic [DATA_W-1:0] reqWdata = 4'h0;
    logic reqReady, rspValid, memSelectN, memOutEnN, memWriteN, memDataOe, memDrives;
    logic [DATA_W-1:0] rspRdata, memDataOut, memDataIn, memOut;
    logic [ADDR_W-1:0] memAddr;
    logic [ADDR_W-1:0] addrs [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
    logic [DATA_W-1:0] vals [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    // Bus level: controller when it drives, else the memory side
    assign memDataIn = memDataOe ? memDataOut : memOut;
    always #50 clock = ~clock;
    asram_ctrl dut_u (.clock(clock), .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid),
        .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .rspValid(rspValid), .rspRdata(rspRdata), .memSelectN(memSelectN),
        .memOutEnN(memOutEnN), .memWriteN(memWriteN), .memAddr(memAddr),
        .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));
    asram_mem_model mem_u (.selectN(memSelectN), .outEnN(memOutEnN), .writeN(memWriteN),
        .addr(memAddr), .busIn(memDataIn), .busDriven(memDataOe), .dataOut(memOut),
        .dataOe(memDrives));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Cut a hung handshake short
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            wrap_up();
        end
    end
    // Controller and memory must never drive the bus together
    always @(negedge clock)
        if (resetn)
            check(memDrives & memDataOe, 1'b0);
    // Wait for ready, present one request, drop it after the taking edge
    task automatic send(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clock);
        while (!reqReady)
            @(negedge clock);
        @(posedge clock);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        @(posedge clock);
        reqValid <= 1'b0;
    endtask
    // Wait a bounded time for the read answer and judge it
    task automatic answer(input logic [DATA_W-1:0] want);
        int n;
        n = 0;
        while (!rspValid && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        check(rspValid, 1'b1);
        check(rspRdata, want);
    endtask
    task automatic read_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
        send(1'b0, a, 4'h0);
        answer(want);
    endtask
    // Idle pins: deselected, strobes high, bus released
    task automatic t_idle;
        @(negedge clock);
        check({memSelectN, memWriteN, memOutEnN, memDataOe, reqReady}, 5'h1D);
    endtask
    // Back-to-back writes at edge and alternating-bit addresses, then read them all
    task automatic t_write_read;
        for (int i = 0; i < 4; i++)
            send(1'b1, addrs[i], vals[i]);
        for (int i = 0; i < 4; i++)
            read_check(addrs[i], vals[i]);
    endtask
    // A second request while busy must be ignored
    task automatic t_refused;
        send(1'b1, 14'h0200, 4'h6);
        @(posedge clock);
        reqValid <= 1'b1;
        reqAddr <= addrs[2];
        reqWdata <= 4'h9;
        @(posedge clock);
        reqValid <= 1'b0;
        read_check(addrs[2], vals[2]);
        read_check(14'h0200, 4'h6);
    endtask
    // Words survive reads; one rewrite leaves the others alone
    task automatic t_persist;
        send(1'b1, addrs[0], 4'h3);
        for (int i = 0; i < 4; i++)
            read_check(addrs[i], (i == 0) ? 4'h3 : vals[i]);
        t_idle();
    endtask
    // Clock enable low mid-read freezes pins and answer, then the read resumes
    task automatic t_freeze;
        send(1'b0, addrs[1], 4'h0);
        @(posedge clock);
        clkEn <= 1'b0;
        repeat (10) @(negedge clock);
        check({memSelectN, memOutEnN, rspValid, reqReady}, 4'h0);
        @(posedge clock);
        clkEn <= 1'b1;
        answer(vals[1]);
    endtask
    // Reset right after a write is taken drops it and releases the pins
    task automatic t_reset;
        send(1'b1, addrs[3], 4'h7);
        resetn <= 1'b0;
        @(negedge clock);
        check({memSelectN, memWriteN, memOutEnN, memDataOe, reqReady}, 5'h1D);
        @(posedge clock);
        resetn <= 1'b1;
        read_check(addrs[3], vals[3]);
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_idle();
        t_write_read();
        t_refused();
        t_persist();
        t_freeze();
        t_reset();
        wrap_up();
    end
endmodule
